/* brcs_checker.sv */
// Port checker for the board reset and configuration sequencer
`timescale 1ns/100ps
module brcs_checker (
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic        STANDBY_POWER_GOOD_N,
    input wire logic        MAIN_SUPPLY_GOOD,
    input wire logic        SLEEP_S3,
    input wire logic        DEBUG_PROBE_RESET_REQ_N,
    input wire logic        CPU_RESET_REQ_N,
    input wire logic        MGMT_RESET_REQ_N,
    input wire logic        WATCHDOG_EXPIRED,
    input wire logic [1:0]  CONFIG_MODE_SWITCH,
    input wire logic        REG_WR,
    input wire logic        HARD_RESET_N,
    input wire logic        TEST_RESET_N,
    input wire logic [63:0] CONFIG_PINS,
    input wire logic        MGMT_MCU_RESET,
    input wire logic        MONITOR_ENABLE,
    input wire logic        SYNTH_SCLK,
    input wire logic        SYNTH_SDATA,
    input wire logic        SYNTH_STROBE
);
    // Requests bar the probe; 8 cycles cover sync and write latency
    wire no_req = STANDBY_POWER_GOOD_N && CPU_RESET_REQ_N && MGMT_RESET_REQ_N && !WATCHDOG_EXPIRED && !REG_WR;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    a_probe_no_trst: assert property ((no_req && MAIN_SUPPLY_GOOD) [*8] |=> !$fell(TEST_RESET_N))
        else $error("test reset without full request");
    a_probe_resets: assert property ((!DEBUG_PROBE_RESET_REQ_N) [*6] |-> !HARD_RESET_N)
        else $error("probe left processor running");
    a_main_resets: assert property ((!MAIN_SUPPLY_GOOD && !SLEEP_S3) [*6] |-> !HARD_RESET_N)
        else $error("supply loss left processor running");
    a_s3_holds: assert property ((no_req && DEBUG_PROBE_RESET_REQ_N && SLEEP_S3 && HARD_RESET_N) [*4] |=> HARD_RESET_N)
        else $error("reset taken while in S3");
    a_strobe_in_reset: assert property (SYNTH_STROBE |-> !HARD_RESET_N)
        else $error("strobe while processor running");
    a_strobe_pulse: assert property (SYNTH_STROBE |=> !SYNTH_STROBE)
        else $error("strobe longer than one cycle");
    a_sclk_half: assert property ($rose(SYNTH_SCLK) |-> SYNTH_SCLK [*4] ##1 !SYNTH_SCLK)
        else $error("clock high phase not four cycles");
    a_sdata_hold: assert property (SYNTH_SCLK && $past(SYNTH_SCLK) |-> $stable(SYNTH_SDATA))
        else $error("data moved while clock high");
    a_pins_frozen: assert property (HARD_RESET_N && $past(HARD_RESET_N) |-> $stable(CONFIG_PINS))
        else $error("pins moved while processor running");
    a_bypass_mcu: assert property ((CONFIG_MODE_SWITCH == 2'h0) [*6] |-> MGMT_MCU_RESET && !MONITOR_ENABLE)
        else $error("monitor active in bypass");
    cover property ($rose(HARD_RESET_N));
    cover property (SYNTH_STROBE);
    cover property (!DEBUG_PROBE_RESET_REQ_N && TEST_RESET_N);
    cover property (SLEEP_S3 && !MAIN_SUPPLY_GOOD && HARD_RESET_N);
endmodule : brcs_checker

bind brcs_top brcs_checker u_chk (.*);

/* brcs_pkg.sv */
// Types for the board reset and configuration sequencer
package brcs_pkg;

    typedef enum logic [1:0] {
        BRCS_MODE_BYPASS = 2'h0,
        BRCS_MODE_UNUSED = 2'h1,
        BRCS_MODE_MEMORY = 2'h2,
        BRCS_MODE_INTER  = 2'h3
    } brcs_mode_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } brcs_bus_type;

    typedef struct packed {
        logic full;
        logic keep_aux;
        logic keep_trst;
    } brcs_scope_type;

endpackage : brcs_pkg

/* brcs_regs.svh */
// Constants for the board reset and configuration sequencer
`ifndef BRCS_REGS_SVH
`define BRCS_REGS_SVH

// Register offsets
`define BRCS_ADDR_CTRL      8'h00
`define BRCS_ADDR_STATUS    8'h04
`define BRCS_ADDR_CLKWORD   8'h08
`define BRCS_ADDR_RESET     8'h0c
`define BRCS_ADDR_SW_BASE   8'h20
`define BRCS_ADDR_EN_BASE   8'h40
`define BRCS_ADDR_AUX       8'h60
`define BRCS_ADDR_EEP_SW    8'h80
`define BRCS_ADDR_EEP_EN    8'ha0

// Control bits
`define BRCS_CTRL_SELFCHAR  0
`define BRCS_CTRL_RELOAD    1
`define BRCS_CTRL_GO        2
`define BRCS_CTRL_KEY       3
`define BRCS_CTRL_CONTINUE  4
`define BRCS_CTRL_EEPDONE   5

// Clock-select presets
`define BRCS_WORD_0         24'h270501
`define BRCS_WORD_1         24'h230984
`define BRCS_WORD_2         24'h230381
`define BRCS_WORD_3         24'h230983
`define BRCS_WORD_4         24'h230501
`define BRCS_WORD_5         24'h260381
`define BRCS_WORD_6         24'h210382
`define BRCS_WORD_7         24'h210201

// Timing
`define BRCS_CLK_HZ         40000000
`define BRCS_WAIT_S         20
`define BRCS_WAIT_CYCLES    (`BRCS_WAIT_S * `BRCS_CLK_HZ)
`define BRCS_SER_HALF       4'h3
`define BRCS_CFG_HOLD       8'h0f

`endif

/* brcs_shifter.sv */
// Serial shifter for the 24-bit clock synthesizer control word
`timescale 1ns/100ps
`include "brcs_regs.svh"

module brcs_shifter (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [23:0] word,
    output logic             busy,
    output logic             done,
    output logic             sclk,
    output logic             sdata,
    output logic             strobe
);

    logic [23:0] shreg_q;
    logic [4:0]  bits_q;
    logic [3:0]  div_q;
    logic        phase_q;
    logic        latch_q;

    // MSB first; data changes while the clock is low
    always_ff @(posedge clk) begin
        if (rst) begin
            shreg_q <= 24'h000000;
            bits_q  <= 5'h00;
            div_q   <= 4'h0;
            phase_q <= 1'b0;
            busy    <= 1'b0;
            done    <= 1'b0;
            sclk    <= 1'b0;
            sdata   <= 1'b0;
            strobe  <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            done   <= 1'b0;
            strobe <= 1'b0;
            if (latch_q) begin
                latch_q <= 1'b0;
                strobe  <= 1'b1;
                done    <= 1'b1;
                busy    <= 1'b0;
            end else if (!busy) begin
                if (start) begin
                    shreg_q <= word;
                    bits_q  <= 5'h18;
                    busy    <= 1'b1;
                    div_q   <= 4'h0;
                    phase_q <= 1'b0;
                    sdata   <= word[23];
                end
            end else if (div_q == `BRCS_SER_HALF) begin
                div_q   <= 4'h0;
                phase_q <= ~phase_q;
                sclk    <= ~phase_q;
                if (phase_q) begin
                    shreg_q <= {shreg_q[22:0], 1'b0};
                    sdata   <= shreg_q[22];
                    bits_q  <= bits_q - 5'h01;
                    if (bits_q == 5'h01) begin
                        latch_q <= 1'b1;
                    end
                end
            end else begin
                div_q <= div_q + 4'h1;
            end
        end
    end

endmodule : brcs_shifter

/* brcs_synth_model.sv */
// Behavioural model of the clock synthesizer serial port
`timescale 1ns/100ps
module brcs_synth_model (
    input  wire logic        clk,
    input  wire logic        sclk,
    input  wire logic        sdata,
    input  wire logic        strobe,
    output logic      [23:0] word,
    output logic      [7:0]  nbits,
    output logic      [7:0]  loads
);
    logic [23:0] sr = 24'h0;
    logic [7:0]  cnt = 8'h0;
    logic        sclk_p = 1'b0;
    initial {word, nbits, loads} = 40'h0;
    // A serial clock rise is seen one edge late
    always @(posedge clk) begin
        sclk_p <= sclk;
        if (sclk && !sclk_p) begin
            sr <= {sr[22:0], sdata};
            cnt <= cnt + 8'h1;
        end
        // Only the strobe commits; nbits shows a short frame
        if (strobe) begin
            word <= sr;
            nbits <= cnt;
            cnt <= 8'h0;
            loads <= loads + 8'h1;
        end
    end
endmodule : brcs_synth_model

/* brcs_tb.sv */
// Self-checking bench for the board reset and configuration sequencer
`timescale 1ns/100ps
module tb;
    logic        clk_sys = 1'b0, rst = 1'b1, sb_n = 1'b1, main_ok = 1'b1, s3 = 1'b0;
    logic        probe_n = 1'b1, cpu_n = 1'b1, mgmt_n = 1'b1, wdog = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [2:0]  clk_sel = 3'h0;
    logic [1:0]  mode = 2'h0;
    logic [63:0] sw = 64'h0123456789abcdef;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic        hrst_n, trst_n, mcu_rst, mon_en, sclk, sdata, strobe;
    logic [63:0] pins;
    logic [23:0] word;
    logic [7:0]  nbits, loads, l0;
    int          errors = 0, checks_done = 0;
    logic [23:0] preset [8] = '{24'h270501, 24'h230984, 24'h230381, 24'h230983,
                                24'h230501, 24'h260381, 24'h210382, 24'h210201};
    always #12.5 clk_sys = ~clk_sys;
    // Short console wait for quick boots
    brcs_top #(.WAIT_CYCLES(32'h32)) u_dut (
        .CLK_SYS(clk_sys), .RST(rst), .STANDBY_POWER_GOOD_N(sb_n), .MAIN_SUPPLY_GOOD(main_ok),
        .SLEEP_S3(s3), .DEBUG_PROBE_RESET_REQ_N(probe_n), .CPU_RESET_REQ_N(cpu_n),
        .MGMT_RESET_REQ_N(mgmt_n), .WATCHDOG_EXPIRED(wdog), .CLOCK_SELECT_SW(clk_sel),
        .CONFIG_MODE_SWITCH(mode), .CONFIG_SWITCHES(sw), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .HARD_RESET_N(hrst_n), .TEST_RESET_N(trst_n),
        .CONFIG_PINS(pins), .MGMT_MCU_RESET(mcu_rst), .MONITOR_ENABLE(mon_en),
        .SYNTH_SCLK(sclk), .SYNTH_SDATA(sdata), .SYNTH_STROBE(strobe));
    brcs_synth_model u_synth (.clk(clk_sys), .sclk(sclk), .sdata(sdata), .strobe(strobe),
        .word(word), .nbits(nbits), .loads(loads));
    task test_done;
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    task chk(input logic [63:0] g, e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [7:0] a);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task wait_hrst(input logic v);
        int n;
        n = 0;
        while (hrst_n !== v && n < 3000) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(hrst_n, v);
    endtask : wait_hrst
    task boot;
        wait_hrst(1'b0);
        wait_hrst(1'b1);
    endtask : boot
    task do_rst;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
    endtask : do_rst
    task hold(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : hold
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_presets;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            clk_sel <= i[2:0];
            do_rst;
            boot;
            chk(word, preset[i]);
            chk(nbits, 8'h18);
            chk(pins, sw);
            chk({mcu_rst, mon_en}, 2'h2);
        end
    endtask : t_presets
    task t_reqs;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            {probe_n, cpu_n, mgmt_n, wdog} <= 4'he ^ (4'h8 >> k);
            hold(10);
            chk(hrst_n, 1'b0);
            if (k == 0) chk(trst_n, 1'b1);
            @(posedge clk_sys);
            {probe_n, cpu_n, mgmt_n, wdog} <= 4'he;
            boot;
        end
    endtask : t_reqs
    task t_s3;
        @(posedge clk_sys);
        s3 <= 1'b1;
        main_ok <= 1'b0;
        hold(12);
        chk(hrst_n, 1'b1);
        s3 <= 1'b0;
        hold(12);
        chk(hrst_n, 1'b0);
        main_ok <= 1'b1;
        boot;
    endtask : t_s3
    task t_aux;
        wr_reg(8'h60, 32'h5a);
        wr_reg(8'h00, 32'h4);
        boot;
        rd_reg(8'h60);
        chk(d, 32'h5a);
        wr_reg(8'h0c, 32'h1);
        boot;
        rd_reg(8'h60);
        chk(d, 32'h0);
        rd_reg(8'hf0);
        chk(d, 32'h0);
    endtask : t_aux
    task t_reload;
        l0 = loads;
        wr_reg(8'h00, 32'h2);
        hold(400);
        chk(loads, l0 + 8'h1);
        chk(nbits, 8'h18);
        chk(hrst_n, 1'b1);
    endtask : t_reload
    task t_override;
        @(posedge clk_sys);
        mode <= 2'h2;
        wr_reg(8'h20, 32'ha5);
        wr_reg(8'h40, 32'h0f);
        wr_reg(8'h08, 32'h123456);
        wr_reg(8'h0c, 32'h1);
        boot;
        chk(pins, {sw[63:8], 8'he5});
        chk(word, 24'h123456);
        @(posedge clk_sys);
        mode <= 2'h0;
        wr_reg(8'h0c, 32'h1);
        boot;
        chk(pins, sw);
    endtask : t_override
    task t_standby;
        @(posedge clk_sys);
        sb_n <= 1'b0;
        hold(4);
        sb_n <= 1'b1;
        boot;
        chk(word, preset[clk_sel]);
    endtask : t_standby
    task t_eep;
        @(posedge clk_sys);
        mode <= 2'h2;
        wr_reg(8'h80, 32'h3c);
        wr_reg(8'ha0, 32'hff);
        wr_reg(8'h00, 32'h20);
        wr_reg(8'h0c, 32'h1);
        boot;
        chk(pins[7:0], 8'h3c);
        wr_reg(8'h20, 32'hc3);
        wr_reg(8'h00, 32'h21);
        wr_reg(8'h0c, 32'h1);
        boot;
        chk(pins[7:0], 8'hc3);
    endtask : t_eep
    task t_inter;
        @(posedge clk_sys);
        mode <= 2'h3;
        do_rst;
        boot;
        chk(nbits, 8'h18);
        chk(pins, sw);
    endtask : t_inter
    initial begin
        do_rst;
        boot;
        t_presets;
        t_reqs;
        t_s3;
        t_aux;
        t_reload;
        t_override;
        t_standby;
        t_eep;
        t_inter;
        test_done;
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        test_done;
    end
endmodule : tb

/* brcs_top.sv */
// Board reset sequencer: reset scopes, synthesizer load and configuration pins
//
// Summary of operation
// R1: Every reset or power-up shifts a 24-bit word into the clock synthesizer.
// R2: The synthesizer word is preset from three switches sampled at reset.
// R3: Codes 000..011 preset 0x270501, 0x230984, 0x230381, 0x230983.
// R4: Codes 100..111 preset 0x230501, 0x260381, 0x210382, 0x210201.
// R5: Word is sent at startup and again on microsequencer reload command.
// R6: Software may overwrite the synthesizer word for the next restart.
// R7: Wait for resets to clear, configure, release processor, then idle.
// R8: Standby power good low restarts all state and registers.
// R9: Main supply good low causes full reset, except in S3 state.
// R10: Debug probe request resets but never asserts test-logic reset.
// R11: Processor, microcontroller and reset-register requests cause full reset.
// R12: Self-characterization restart is full reset keeping auxiliary registers.
// R13: Watchdog expiry does a full restart applying pending override changes.
// R14: By default switches drive configuration pins during hard reset.
// R15: Software may write switch value and enable override registers.
// R16: Overrides may be loaded from the external EEPROM at reset.
// R17: Mode switch: 00 bypass, 01 unused, 10 memory, 11 interactive.
// R18: Bypass uses switches only; microcontroller held, no monitoring or voltage.
// R19: Memory mode keeps overrides while self-char flag set, else loads EEPROM.
// R20: Enabled override bits replace switch bits on configuration lines.
// R21: Interactive mode waits up to 20 s for input, then memory mode.
// R22: Processor stays in reset until word shifted and pins final.
`timescale 1ns/100ps
`include "brcs_regs.svh"

module brcs_top #(
    parameter logic [31:0] WAIT_CYCLES = `BRCS_WAIT_CYCLES
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        STANDBY_POWER_GOOD_N,
    input  wire logic        MAIN_SUPPLY_GOOD,
    input  wire logic        SLEEP_S3,
    input  wire logic        DEBUG_PROBE_RESET_REQ_N,
    input  wire logic        CPU_RESET_REQ_N,
    input  wire logic        MGMT_RESET_REQ_N,
    input  wire logic        WATCHDOG_EXPIRED,
    input  wire logic [2:0]  CLOCK_SELECT_SW,
    input  wire logic [1:0]  CONFIG_MODE_SWITCH,
    input  wire logic [63:0] CONFIG_SWITCHES,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [31:0]      REG_RDATA,
    output logic             HARD_RESET_N,
    output logic             TEST_RESET_N,
    output logic [63:0]      CONFIG_PINS,
    output logic             MGMT_MCU_RESET,
    output logic             MONITOR_ENABLE,
    output logic             SYNTH_SCLK,
    output logic             SYNTH_SDATA,
    output logic             SYNTH_STROBE
);

    // ------------------------
    // Input synchronisers
    // ------------------------
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] raw_in, meta_q, sync_q;
    logic [63:0]      sw_meta_q, sw_sync_q;
    logic [1:0]       mode_meta_q, mode_sync_q;

    assign raw_in = {STANDBY_POWER_GOOD_N, MAIN_SUPPLY_GOOD, SLEEP_S3, DEBUG_PROBE_RESET_REQ_N,
                     CPU_RESET_REQ_N, MGMT_RESET_REQ_N, WATCHDOG_EXPIRED, CLOCK_SELECT_SW[2:0]};

    always_ff @(posedge CLK_SYS) begin
        meta_q    <= raw_in;
        sync_q    <= meta_q;
        sw_meta_q <= CONFIG_SWITCHES;
        sw_sync_q <= sw_meta_q;
        mode_meta_q <= CONFIG_MODE_SWITCH;
        mode_sync_q <= mode_meta_q;
    end

    logic standby_good, main_good, in_s3, probe_req, cpu_req, mgmt_req, wdt_req;
    logic [2:0] clk_sel;
    assign standby_good = sync_q[9];
    assign main_good    = sync_q[8];
    assign in_s3        = sync_q[7];
    assign probe_req    = ~sync_q[6];
    assign cpu_req      = ~sync_q[5];
    assign mgmt_req     = ~sync_q[4];
    assign wdt_req      = sync_q[3];
    assign clk_sel      = sync_q[2:0];

    brcs_pkg::brcs_mode_type mode;
    assign mode = brcs_pkg::brcs_mode_type'(mode_sync_q); // R17

    // Whole-block reset: the pin reset or loss of standby power
    logic rst_all;
    assign rst_all = RST | ~standby_good; // R8

    // ------------------------
    // Preset lookup
    // ------------------------
    function automatic logic [23:0] preset_word(input logic [2:0] sel);
        logic [23:0] w;
        w = `BRCS_WORD_0;
        unique case (sel)
            3'h0: w = `BRCS_WORD_0; // R3
            3'h1: w = `BRCS_WORD_1; // R3
            3'h2: w = `BRCS_WORD_2; // R3
            3'h3: w = `BRCS_WORD_3; // R3
            3'h4: w = `BRCS_WORD_4; // R4
            3'h5: w = `BRCS_WORD_5; // R4
            3'h6: w = `BRCS_WORD_6; // R4
            3'h7: w = `BRCS_WORD_7; // R4
        endcase
        return w;
    endfunction : preset_word

    // ------------------------
    // Register port
    // ------------------------
    brcs_pkg::brcs_bus_type bus;
    assign bus = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

    logic wr_ctrl, wr_clk, wr_rst, wr_aux, wr_sw, wr_en, wr_esw, wr_een;
    assign wr_ctrl = bus.wr && bus.addr == `BRCS_ADDR_CTRL;
    assign wr_clk  = bus.wr && bus.addr == `BRCS_ADDR_CLKWORD;
    assign wr_rst  = bus.wr && bus.addr == `BRCS_ADDR_RESET;
    assign wr_aux  = bus.wr && bus.addr == `BRCS_ADDR_AUX;
    assign wr_sw   = bus.wr && bus.addr[7:5] == `BRCS_ADDR_SW_BASE >> 5 && bus.addr[1:0] == 2'h0;
    assign wr_en   = bus.wr && bus.addr[7:5] == `BRCS_ADDR_EN_BASE >> 5 && bus.addr[1:0] == 2'h0;
    assign wr_esw  = bus.wr && bus.addr[7:5] == `BRCS_ADDR_EEP_SW >> 5 && bus.addr[1:0] == 2'h0;
    assign wr_een  = bus.wr && bus.addr[7:5] == `BRCS_ADDR_EEP_EN >> 5 && bus.addr[1:0] == 2'h0;

    logic [7:0]  sw_q [8], en_q [8], esw_q [8], een_q [8];
    logic [31:0] aux_q;
    logic [23:0] clkword_q;
    logic        clk_custom_q, selfchar_q, eep_valid_q;

    // ------------------------
    // Sequencer
    // ------------------------
    typedef enum logic [2:0] {
        S_WAIT_CLEAR, S_LOAD, S_HOLD_KEY, S_SHIFT, S_DRIVE, S_RUN
    } brcs_state_type;
    brcs_state_type state_q;

    brcs_pkg::brcs_scope_type scope;
    logic reload_cmd, mem_load, shift_start, shift_busy, shift_done;
    logic [31:0] wait_q;
    logic [7:0]  hold_q;
    logic        key_q, first_q;

    // Full-reset sources; only the probe request spares test reset
    always_comb begin
        scope.full      = (main_good == 1'b0 && !in_s3) || probe_req || cpu_req || mgmt_req // R9 R10 R11
                          || wr_rst || wdt_req || (wr_ctrl && bus.wdata[`BRCS_CTRL_GO]); // R11 R12 R13
        scope.keep_aux  = wr_ctrl && bus.wdata[`BRCS_CTRL_GO]; // R12
        scope.keep_trst = probe_req && !(cpu_req || mgmt_req || wr_rst || wdt_req); // R10
    end

    assign reload_cmd = wr_ctrl && bus.wdata[`BRCS_CTRL_RELOAD]; // R5
    assign mem_load   = mode != brcs_pkg::BRCS_MODE_BYPASS && mode != brcs_pkg::BRCS_MODE_UNUSED
                        && !selfchar_q && eep_valid_q; // R19
    assign shift_start = state_q == S_SHIFT && !shift_busy && !shift_done;

    always_ff @(posedge CLK_SYS) begin
        if (rst_all) begin
            state_q <= S_WAIT_CLEAR;
            wait_q  <= 32'h00000000;
            hold_q  <= 8'h00;
            key_q   <= 1'b0;
            first_q <= 1'b1;
        end else begin
            if (wr_ctrl && bus.wdata[`BRCS_CTRL_KEY]) begin
                key_q <= 1'b1;
            end
            unique case (state_q)
                S_WAIT_CLEAR: begin
                    if (!scope.full && main_good) begin // R7
                        state_q <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    wait_q  <= 32'h00000000;
                    state_q <= (mode == brcs_pkg::BRCS_MODE_INTER && first_q) ? S_HOLD_KEY : S_SHIFT;
                end
                S_HOLD_KEY: begin
                    // Pause for console; a key holds until software continues
                    wait_q <= wait_q + 32'h00000001;
                    if ((!key_q && wait_q >= WAIT_CYCLES) // R21
                        || (wr_ctrl && bus.wdata[`BRCS_CTRL_CONTINUE])) begin
                        state_q <= S_SHIFT;
                    end
                end
                S_SHIFT: begin
                    if (shift_done) begin // R22
                        hold_q  <= 8'h00;
                        state_q <= S_DRIVE;
                    end
                end
                S_DRIVE: begin
                    hold_q <= hold_q + 8'h01;
                    if (hold_q == `BRCS_CFG_HOLD) begin // R22
                        state_q <= S_RUN;
                        first_q <= 1'b0;
                    end
                end
                S_RUN: begin
                    if (reload_cmd) begin // R5
                        state_q <= S_SHIFT;
                    end
                end
            endcase
            if (scope.full) begin // R1
                state_q <= S_WAIT_CLEAR;
            end
        end
    end

    // ------------------------
    // Synthesizer word
    // ------------------------
    always_ff @(posedge CLK_SYS) begin
        if (rst_all) begin
            clkword_q    <= `BRCS_WORD_0;
            clk_custom_q <= 1'b0;
        end else if (wr_clk) begin
            clkword_q    <= bus.wdata[23:0]; // R6
            clk_custom_q <= 1'b1;
        end else if (state_q == S_WAIT_CLEAR && !clk_custom_q) begin
            clkword_q <= preset_word(clk_sel); // R2
        end
    end

    brcs_shifter u_shifter (
        .clk    (CLK_SYS),
        .rst    (rst_all),
        .start  (shift_start), // R1
        .word   (clkword_q),
        .busy   (shift_busy),
        .done   (shift_done),
        .sclk   (SYNTH_SCLK),
        .sdata  (SYNTH_SDATA),
        .strobe (SYNTH_STROBE)
    );

    // ------------------------
    // Override registers
    // ------------------------
    always_ff @(posedge CLK_SYS) begin
        if (rst_all) begin
            selfchar_q  <= 1'b0;
            eep_valid_q <= 1'b0;
            aux_q       <= 32'h00000000;
        end else begin
            if (wr_ctrl) begin
                selfchar_q  <= bus.wdata[`BRCS_CTRL_SELFCHAR];
                eep_valid_q <= bus.wdata[`BRCS_CTRL_EEPDONE];
            end
            if (wr_aux) begin
                aux_q <= bus.wdata;
            end else if (scope.full && !scope.keep_aux) begin
                aux_q <= 32'h00000000; // R12
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_ovr
            always_ff @(posedge CLK_SYS) begin
                if (rst_all) begin
                    sw_q[gi]  <= 8'h00;
                    en_q[gi]  <= 8'h00;
                    esw_q[gi] <= 8'h00;
                    een_q[gi] <= 8'h00;
                end else begin
                    if (wr_esw && bus.addr[4:2] == 3'(gi)) begin
                        esw_q[gi] <= bus.wdata[7:0];
                    end
                    if (wr_een && bus.addr[4:2] == 3'(gi)) begin
                        een_q[gi] <= bus.wdata[7:0];
                    end
                    if (state_q == S_LOAD && mem_load) begin // R16 R19
                        sw_q[gi] <= esw_q[gi];
                        en_q[gi] <= een_q[gi];
                    end else begin
                        if (wr_sw && bus.addr[4:2] == 3'(gi)) begin
                            sw_q[gi] <= bus.wdata[7:0]; // R15
                        end
                        if (wr_en && bus.addr[4:2] == 3'(gi)) begin
                            en_q[gi] <= bus.wdata[7:0]; // R15
                        end
                    end
                end
            end
        end
    endgenerate

    // ------------------------
    // Processor pins
    // ------------------------
    logic [63:0] mux_cfg;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_mux
            // Bypass ignores the overrides entirely
            assign mux_cfg[gi*8 +: 8] = (mode == brcs_pkg::BRCS_MODE_BYPASS) ? sw_sync_q[gi*8 +: 8] // R18
                : (en_q[gi] & sw_q[gi]) | (~en_q[gi] & sw_sync_q[gi*8 +: 8]); // R14 R20
        end
    endgenerate

    always_ff @(posedge CLK_SYS) begin
        if (rst_all) begin
            HARD_RESET_N   <= 1'b0;
            TEST_RESET_N   <= 1'b0;
            CONFIG_PINS    <= 64'h0000000000000000;
            MGMT_MCU_RESET <= 1'b1;
            MONITOR_ENABLE <= 1'b0;
        end else begin
            HARD_RESET_N <= state_q == S_RUN && !scope.full; // R7 R22
            if (scope.full && !scope.keep_trst) begin
                TEST_RESET_N <= 1'b0; // R10
            end else if (state_q == S_RUN) begin
                TEST_RESET_N <= 1'b1;
            end
            if (state_q != S_RUN) begin
                CONFIG_PINS <= mux_cfg; // R14
            end
            MGMT_MCU_RESET <= mode == brcs_pkg::BRCS_MODE_BYPASS; // R18
            MONITOR_ENABLE <= mode != brcs_pkg::BRCS_MODE_BYPASS; // R18
        end
    end

    // ------------------------
    // Read path
    // ------------------------
    always_ff @(posedge CLK_SYS) begin
        if (rst_all) begin
            REG_RDATA <= 32'h00000000;
        end else begin
            REG_RDATA <= 32'h00000000;
            if (bus.rd) begin
                if (bus.addr == `BRCS_ADDR_CTRL) begin
                    REG_RDATA <= {24'h000000, 2'h0, eep_valid_q, 1'b0, key_q, 2'h0, selfchar_q};
                end else if (bus.addr == `BRCS_ADDR_STATUS) begin
                    REG_RDATA <= {16'h0000, 3'h0, clk_sel, mode_sync_q, 5'h00, state_q};
                end else if (bus.addr == `BRCS_ADDR_CLKWORD) begin
                    REG_RDATA <= {8'h00, clkword_q};
                end else if (bus.addr == `BRCS_ADDR_AUX) begin
                    REG_RDATA <= aux_q;
                end else if (bus.addr[7:5] == `BRCS_ADDR_SW_BASE >> 5) begin
                    REG_RDATA <= {24'h000000, sw_q[bus.addr[4:2]]};
                end else if (bus.addr[7:5] == `BRCS_ADDR_EN_BASE >> 5) begin
                    REG_RDATA <= {24'h000000, en_q[bus.addr[4:2]]};
                end
            end
        end
    end

endmodule : brcs_top
